// file: rtl/i2c_link_pkg.sv
/*
  Constants, commands and state types shared by both ends of the serial link.
  Assumes a 200 MHz system clock and an open-drain bus with pull-ups.
*/
// Behaviour
// RULE_01 - master sends HS code at F/S rate
// RULE_02 - slave leaves HS code unacked, enters HS
// RULE_03 - after repeated start, same protocol, faster
// RULE_04 - master keeps HS with repeated starts
// RULE_05 - stop ends HS, filters back to F/S
// RULE_06 - alert response address is recognised
// RULE_07 - alerting slave acks, sends own address
// RULE_08 - arbitration loser stops, keeps alert low
// RULE_09 - address from two select pins, per transaction
// RULE_10 - abandon stalled transaction after 28 ms
// RULE_11 - all bytes shifted MSB first
// RULE_12 - winner releases alert, returns to idle
package i2c_link_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Bus codes
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;  // 00001xxx
  localparam logic [7:0] HS_MASTER_CODE = 8'h08;
  localparam logic [6:0] ALERT_RSP_ADDR = 7'h0C; // 0001100
  localparam logic [4:0] SLAVE_ADDR_TOP = 5'h10; // 10000xx

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int CLK_MHZ          = 200;
  localparam int SCL_FS_PERIOD_PS = 2500000;  // 400 kHz
  localparam int SCL_HS_PERIOD_PS = 294118;   // 3.4 MHz
  localparam int QTR_FS_CYC       = (SCL_FS_PERIOD_PS + 4 * CLK_PERIOD_PS - 1) / (4 * CLK_PERIOD_PS);
  localparam int QTR_HS_CYC       = (SCL_HS_PERIOD_PS + 4 * CLK_PERIOD_PS - 1) / (4 * CLK_PERIOD_PS);
  localparam int TMO_US           = 28000;    // 28 ms
  localparam int TMO_CYC          = TMO_US * CLK_MHZ;
  localparam int TMO_W            = 23;

  ////////////////////////////////////////////////////////////////////////
  // Sequence lengths and reset values
  localparam logic [4:0] HS_SEQ_BITS  = 5'h09;
  localparam logic [4:0] ARA_SEQ_BITS = 5'h12;
  localparam logic [2:0] BYTE_LAST    = 3'h7;
  localparam logic       ALERT_N_RST  = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Commands and states
  typedef enum logic [1:0] {OP_HS = 2'h0, OP_ARA = 2'h1, OP_STOP = 2'h2} op_t;
  typedef enum logic [2:0] {M_IDLE = 3'h0, M_START = 3'h1, M_BIT = 3'h3, M_STOP = 3'h2,
                            M_HOLD = 3'h6} mst_t;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_ADDR = 2'h1, S_ACK = 2'h3, S_SEND = 2'h2} slv_t;

endpackage

// file: rtl/i2c_link_if.sv
/*
  Open-drain two-wire link between the bus master end and the slave end.
  Assumes pull-ups: a line is low only while some end enables a low drive.
*/
`timescale 1ns/1ps
interface i2c_link_if;
  // Master drives
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  // Slave drives
  logic s_sda_o;
  logic s_sda_oe;
  // Resolved wire levels
  logic scl_in;
  logic sda_in;

  // Wired-AND with pull-up
  assign scl_in = ~(m_scl_oe & ~m_scl_o);
  assign sda_in = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl_in, sda_in);
  modport slave  (output s_sda_o, s_sda_oe, input scl_in, sda_in);
endinterface

// file: rtl/i2c_alert_slave.sv
/*
  Slave end: high-speed mode entry and exit, alert response with arbitration,
  stalled-bus timeout. Protocol logic runs on the bus clock; alert, filter
  select and timeout run on clk_sys. Assumes the master sequences the bus.
*/
`timescale 1ns/1ps
module i2c_alert_slave
  import i2c_link_pkg::*;
#(
  parameter int TMO_CYCLES = i2c_link_pkg::TMO_CYC
)(
  // System clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Bus
  i2c_link_if.slave bus,
  // User side
  input  wire logic alert_set,
  input  wire logic address_select_low_pin,
  input  wire logic address_select_high_pin,
  output logic      alert_n_o,
  output logic      hs_mode_o
);
  import i2c_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Start and stop edge catchers, clocked by sda itself
  logic start_tog_r;
  logic stop_tog_r;

  always_ff @(negedge bus.sda_in or negedge arst_n)
    if (!arst_n)
      start_tog_r <= 1'b0;
    else if (bus.scl_in)
      start_tog_r <= ~start_tog_r;

  always_ff @(posedge bus.sda_in or negedge arst_n)
    if (!arst_n)
      stop_tog_r <= 1'b0;
    else if (bus.scl_in)
      stop_tog_r <= ~stop_tog_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus clock domain
  slv_t       st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic       start_seen_r, start_seen_nxt;
  logic       abort_seen_r, abort_seen_nxt;
  logic       hs_tog_r, hs_tog_nxt;
  logic       done_tog_r, done_tog_nxt;
  logic [6:0] own_addr_r, own_addr_nxt;
  logic [3:0] l_s1_r;
  logic [3:0] l_s2_r;
  logic       drv_r;
  logic       abort_tog_r;
  logic       alert_pend_r;

  // Alert, abort and select pins into the bus clock domain
  always_ff @(posedge bus.scl_in or negedge arst_n)
    if (!arst_n)
    begin
      l_s1_r <= 4'h0;
      l_s2_r <= 4'h0;
    end
    else
    begin
      l_s1_r <= {alert_pend_r, abort_tog_r, address_select_high_pin, address_select_low_pin};
      l_s2_r <= l_s1_r;
    end

  // Receive, recognise, answer
  always_comb
  begin
    st_nxt         = st_r;
    cnt_nxt        = cnt_r;
    sh_nxt         = sh_r;
    start_seen_nxt = start_tog_r;
    abort_seen_nxt = l_s2_r[2];
    hs_tog_nxt     = hs_tog_r;
    done_tog_nxt   = done_tog_r;
    own_addr_nxt   = own_addr_r;
    if (start_tog_r != start_seen_r)
    begin
      st_nxt       = S_ADDR;
      cnt_nxt      = 3'h1;
      sh_nxt       = {7'h00, bus.sda_in};
    end
    else if (l_s2_r[2] != abort_seen_r)
      st_nxt = S_IDLE;  // [RULE_10]
    else
      unique case (st_r)
        S_IDLE: ;
        S_ADDR:
        begin
          sh_nxt  = {sh_r[6:0], bus.sda_in};  // [RULE_11]
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == BYTE_LAST)
          begin
            st_nxt       = S_IDLE;
            own_addr_nxt = {SLAVE_ADDR_TOP, l_s2_r[1:0]};  // Pins of this transaction [RULE_09]
            if (sh_nxt[7:3] == HS_CODE_TOP)
              hs_tog_nxt = ~hs_tog_r;  // No ack, enter HS [RULE_02] [RULE_03]
            else if (sh_nxt == {ALERT_RSP_ADDR, 1'b1} && l_s2_r[3])
              st_nxt = S_ACK;  // [RULE_06] [RULE_07]
          end
        end
        S_ACK:
        begin
          st_nxt  = S_SEND;
          cnt_nxt = 3'h0;
          sh_nxt  = {own_addr_r, 1'b0};  // [RULE_07]
        end
        S_SEND:
        begin
          cnt_nxt = cnt_r + 3'h1;
          sh_nxt  = {sh_r[6:0], 1'b1};  // [RULE_11]
          if (bus.sda_in != sh_r[7])
            st_nxt = S_IDLE;  // Lost: alert stays [RULE_08]
          else if (cnt_r == BYTE_LAST)
          begin
            st_nxt       = S_IDLE;  // [RULE_12]
            done_tog_nxt = ~done_tog_r;
          end
        end
        default: st_nxt = S_IDLE;
      endcase
  end

  always_ff @(posedge bus.scl_in or negedge arst_n)
    if (!arst_n)
    begin
      st_r         <= S_IDLE;
      cnt_r        <= 3'h0;
      sh_r         <= 8'h00;
      start_seen_r <= 1'b0;
      abort_seen_r <= 1'b0;
      hs_tog_r     <= 1'b0;
      done_tog_r   <= 1'b0;
      own_addr_r   <= {SLAVE_ADDR_TOP, 2'h0};
    end
    else
    begin
      st_r         <= st_nxt;
      cnt_r        <= cnt_nxt;
      sh_r         <= sh_nxt;
      start_seen_r <= start_seen_nxt;
      abort_seen_r <= abort_seen_nxt;
      hs_tog_r     <= hs_tog_nxt;
      done_tog_r   <= done_tog_nxt;
      own_addr_r   <= own_addr_nxt;
    end

  // Data changes only while the clock is low
  always_ff @(negedge bus.scl_in or negedge arst_n)
    if (!arst_n)
      drv_r <= 1'b0;
    else
      drv_r <= (st_r == S_ACK) || (st_r == S_SEND && !sh_r[7]);

  ////////////////////////////////////////////////////////////////////////
  // System clock domain
  logic [4:0]       y_s1_r;
  logic [4:0]       y_s2_r;
  logic [4:0]       y_s3_r;
  logic             hs_r, hs_nxt;
  logic             alert_nxt;
  logic             abort_tog_nxt;
  logic [TMO_W-1:0] tmo_cnt_r, tmo_cnt_nxt;
  logic             tmo_r, tmo_nxt;
  logic             hs_ev;
  logic             stop_ev;
  logic             done_ev;

  // Bus events into clk_sys, third stage for edge detection
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      y_s1_r <= 5'h08;  // Idle levels: no drive, SCL high, toggles at rest
      y_s2_r <= 5'h08;
      y_s3_r <= 5'h08;
    end
    else
    begin
      y_s1_r <= {drv_r, bus.scl_in, stop_tog_r, done_tog_r, hs_tog_r};
      y_s2_r <= y_s1_r;
      y_s3_r <= y_s2_r;
    end

  assign hs_ev   = y_s2_r[0] ^ y_s3_r[0];
  assign done_ev = y_s2_r[1] ^ y_s3_r[1];
  assign stop_ev = y_s2_r[2] ^ y_s3_r[2];

  // Filter select, alert level, stall timeout
  always_comb
  begin
    hs_nxt        = hs_r;
    alert_nxt     = alert_pend_r;
    abort_tog_nxt = abort_tog_r;
    tmo_cnt_nxt   = tmo_cnt_r;
    tmo_nxt       = tmo_r;
    if (stop_ev)
      hs_nxt = 1'b0;  // [RULE_05]
    if (hs_ev)
      hs_nxt = 1'b1;  // Set wins [RULE_02]
    if (done_ev)
      alert_nxt = 1'b0;  // [RULE_12]
    if (alert_set)
      alert_nxt = 1'b1;  // Set wins [RULE_08]
    if (y_s2_r[3])
    begin
      tmo_cnt_nxt = '0;
      if (!y_s2_r[4])
        tmo_nxt = 1'b0;  // Line stays free until the answer is dropped [RULE_10]
    end
    else if (tmo_cnt_r == TMO_W'(TMO_CYCLES - 1))
    begin
      if (!tmo_r)
        abort_tog_nxt = ~abort_tog_r;  // [RULE_10]
      tmo_nxt = 1'b1;
    end
    else
      tmo_cnt_nxt = tmo_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      hs_r         <= 1'b0;
      alert_pend_r <= 1'b0;
      abort_tog_r  <= 1'b0;
      tmo_cnt_r    <= '0;
      tmo_r        <= 1'b0;
      alert_n_o    <= ALERT_N_RST;
      hs_mode_o    <= 1'b0;
    end
    else
    begin
      hs_r         <= hs_nxt;
      alert_pend_r <= alert_nxt;
      abort_tog_r  <= abort_tog_nxt;
      tmo_cnt_r    <= tmo_cnt_nxt;
      tmo_r        <= tmo_nxt;
      alert_n_o    <= ~alert_nxt;
      hs_mode_o    <= hs_nxt;
    end

  // Timeout forces the data line free
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = drv_r & ~tmo_r;  // [RULE_10]

endmodule

// file: rtl/i2c_hs_master.sv
/*
  Master end: makes the bus clock from clk_sys by a quarter-period divider,
  enters high-speed mode, runs alert response reads, issues stop.
  Assumes one command at a time, taken only while cmd_ready is high.
*/
`timescale 1ns/1ps
module i2c_hs_master
  import i2c_link_pkg::*;
(
  // System clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Bus
  i2c_link_if.master      bus,
  // Commands
  input  wire logic       cmd_valid,
  input  wire op_t        cmd_op,
  output logic            cmd_ready,
  // Results
  output logic            rsp_valid,
  output logic            rsp_found,
  output logic [6:0]      rsp_addr,
  output logic            hs_active
);
  import i2c_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Data line synchroniser
  logic sda_s1_r;
  logic sda_s2_r;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end
    else
    begin
      sda_s1_r <= bus.sda_in;
      sda_s2_r <= sda_s1_r;
    end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  mst_t        st_r, st_nxt;
  op_t         op_r, op_nxt;
  logic [1:0]  q_r, q_nxt;
  logic [7:0]  div_r, div_nxt;
  logic [4:0]  bits_r, bits_nxt;
  logic [17:0] tx_r, tx_nxt;
  logic [17:0] rx_r, rx_nxt;
  logic        hs_r, hs_nxt;
  logic        scl_oe_r, scl_oe_nxt;
  logic        sda_oe_r, sda_oe_nxt;
  logic        rdy_nxt;
  logic        rv_nxt;
  logic        rf_nxt;
  logic [6:0]  ra_nxt;
  logic        tick;
  logic [7:0]  qlen;

  // Code goes at F/S rate, hs_r rises only after it [RULE_01] [RULE_03]
  assign qlen = hs_r ? 8'(QTR_HS_CYC - 1) : 8'(QTR_FS_CYC - 1);
  assign tick = (div_r == qlen);

  always_comb
  begin
    st_nxt     = st_r;
    op_nxt     = op_r;
    q_nxt      = q_r;
    bits_nxt   = bits_r;
    tx_nxt     = tx_r;
    rx_nxt     = rx_r;
    hs_nxt     = hs_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    rdy_nxt    = cmd_ready;
    rv_nxt     = 1'b0;
    rf_nxt     = rsp_found;
    ra_nxt     = rsp_addr;
    div_nxt    = (tick || st_r == M_IDLE || st_r == M_HOLD) ? 8'h00 : div_r + 8'h01;
    unique case (st_r)
      M_IDLE, M_HOLD:
        if (cmd_valid)
        begin
          rdy_nxt = 1'b0;
          op_nxt  = cmd_op;
          q_nxt   = 2'h0;
          if (cmd_op == OP_STOP)
            st_nxt = M_STOP;
          else
          begin
            st_nxt   = M_START;  // Start, or repeated start in HS [RULE_04]
            bits_nxt = (cmd_op == OP_HS) ? HS_SEQ_BITS : ARA_SEQ_BITS;
            tx_nxt   = (cmd_op == OP_HS) ? {HS_MASTER_CODE, 10'h3FF}
                                         : {ALERT_RSP_ADDR, 11'h7FF};  // [RULE_06]
          end
        end
      M_START:
        if (tick)
        begin
          q_nxt = q_r + 2'h1;
          unique case (q_r)
            2'h0: sda_oe_nxt = 1'b0;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b1;
            2'h3:
            begin
              scl_oe_nxt = 1'b1;
              st_nxt     = M_BIT;
            end
          endcase
        end
      M_BIT:
        if (tick)
        begin
          q_nxt = q_r + 2'h1;
          unique case (q_r)
            2'h0: sda_oe_nxt = ~tx_r[17];  // [RULE_11]
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: rx_nxt = {rx_r[16:0], sda_s2_r};
            2'h3:
            begin
              scl_oe_nxt = 1'b1;
              tx_nxt     = {tx_r[16:0], 1'b1};
              bits_nxt   = bits_r - 5'h01;
              if (bits_r == 5'h01)
              begin
                rv_nxt = 1'b1;
                if (op_r == OP_HS)
                begin
                  hs_nxt  = 1'b1;
                  st_nxt  = M_HOLD;
                  rdy_nxt = 1'b1;
                  rf_nxt  = ~rx_r[0];
                end
                else
                begin
                  rf_nxt = ~rx_r[9];
                  ra_nxt = rx_r[8:2];
                  st_nxt = hs_r ? M_HOLD : M_STOP;  // [RULE_04]
                  rdy_nxt = hs_r;
                end
              end
            end
          endcase
        end
      M_STOP:
        if (tick)
        begin
          q_nxt = q_r + 2'h1;
          unique case (q_r)
            2'h0: sda_oe_nxt = 1'b1;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b0;
            2'h3:
            begin
              st_nxt  = M_IDLE;
              hs_nxt  = 1'b0;  // [RULE_05]
              rdy_nxt = 1'b1;
            end
          endcase
        end
      default: st_nxt = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      st_r      <= M_IDLE;
      op_r      <= OP_HS;
      q_r       <= 2'h0;
      div_r     <= 8'h00;
      bits_r    <= 5'h00;
      tx_r      <= 18'h3FFFF;
      rx_r      <= 18'h3FFFF;
      hs_r      <= 1'b0;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_found <= 1'b0;
      rsp_addr  <= 7'h00;
      hs_active <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      op_r      <= op_nxt;
      q_r       <= q_nxt;
      div_r     <= div_nxt;
      bits_r    <= bits_nxt;
      tx_r      <= tx_nxt;
      rx_r      <= rx_nxt;
      hs_r      <= hs_nxt;
      scl_oe_r  <= scl_oe_nxt;
      sda_oe_r  <= sda_oe_nxt;
      cmd_ready <= rdy_nxt;
      rsp_valid <= rv_nxt;
      rsp_found <= rf_nxt;
      rsp_addr  <= ra_nxt;
      hs_active <= hs_nxt;
    end

  // Open-drain: enable means pull low
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_oe = sda_oe_r;

endmodule

// file: dv/i2c_link_properties.sv
/*
  Checks on the first link: clock rates, high-speed entry and exit, alert answer.
  Assumes link wires and end status are connected by name.
*/
`timescale 1ns/1ps
module i2c_link_properties #(
  parameter int TMO_CYCLES = 1000
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link wires
  input wire logic s_sda_oe,
  input wire logic scl_in,
  input wire logic sda_in,
  // End status
  input wire logic hs_mode_o,
  input wire logic alert_n_o,
  input wire logic hs_active
);
  logic [15:0] per_r, per_nxt, low_r, low_nxt;
  logic [9:0]  age_r, age_nxt;
  logic [7:0]  stp_r, stp_nxt;
  logic        scl_d_r, sda_d_r, hs_d_r;

  // Counters: since SCL rise, SCL low, HS entry, stop
  always_comb
  begin
    per_nxt = (scl_in && !scl_d_r) ? 16'h0001 : per_r + 16'(per_r != 16'hFFFF);
    low_nxt = scl_in ? 16'h0000 : low_r + 16'(low_r != 16'hFFFF);
    age_nxt = (hs_mode_o && !hs_d_r) ? 10'h000 : age_r + 10'(age_r != 10'h3FF);
    stp_nxt = (scl_in && scl_d_r && sda_in && !sda_d_r) ? 8'h00 : stp_r + 8'(stp_r != 8'hFF);
  end

  // Counter registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {per_r, low_r, age_r, stp_r} <= {16'hFFFF, 16'h0000, 10'h3FF, 8'hFF};
      {scl_d_r, sda_d_r, hs_d_r} <= 3'h6;
    end
    else
    begin
      {per_r, low_r, age_r, stp_r} <= {per_nxt, low_nxt, age_nxt, stp_nxt};
      {scl_d_r, sda_d_r, hs_d_r} <= {scl_in, sda_in, hs_mode_o};
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  property p_fs_rate;
    $rose(scl_in) && !hs_active |-> per_r >= 16'h01F4;
  endproperty
  a_fs_rate: assert property (p_fs_rate) else $error("SCL period short at normal rate");
  property p_hs_rate;
    $rose(scl_in) && hs_active |-> per_r >= 16'h003B;
  endproperty
  a_hs_rate: assert property (p_hs_rate) else $error("SCL period short at high speed");
  property p_sda_edge;
    $changed(s_sda_oe) |-> !scl_in;
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("Slave SDA moved with SCL high");
  property p_hs_noack;
    hs_mode_o && age_r < 10'h2BC |-> !s_sda_oe;
  endproperty
  a_hs_noack: assert property (p_hs_noack) else $error("Master code acknowledged");
  property p_hs_exit;
    hs_mode_o && stp_r == 8'h00 |-> ##[1:8] !hs_mode_o;
  endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("High speed kept after stop");
  property p_hs_hold;
    $fell(hs_mode_o) |-> stp_r < 8'h0A;
  endproperty
  a_hs_hold: assert property (p_hs_hold) else $error("High speed left without stop");
  property p_ack_alert;
    $rose(s_sda_oe) |-> !alert_n_o;
  endproperty
  a_ack_alert: assert property (p_ack_alert) else $error("Slave drove SDA with no alert");
  property p_alert_done;
    $rose(alert_n_o) |-> scl_in && s_sda_oe && !sda_in;
  endproperty
  a_alert_done: assert property (p_alert_done) else $error("Alert released off last bit");
  property p_tmo;
    low_r > 16'(TMO_CYCLES + 16) |-> !s_sda_oe;
  endproperty
  a_tmo: assert property (p_tmo) else $error("Slave holds SDA past timeout");
endmodule

// file: dv/hs_mode_alert_response_slave_test.sv
/*
  Bench: master and slave ends face each other on one link; a second slave
  sits on a link the bench drives bit by bit. Assumes the shared package.
*/
`timescale 1ns/1ps
module hs_mode_alert_response_slave_test;
  import i2c_link_pkg::*;

  localparam int TMO = 1000;
  localparam int QB  = 16;  // Quarter of the 64 ns second link clock

  logic       clk_sys, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_found, hs_active;
  logic       alert_set, alert_set_b, alert_n_o, alert_n_b, hs_mode_o, al;
  logic [1:0] pins, pins_b;
  logic [6:0] rsp_addr;
  logic [7:0] e;
  logic [8:0] rx;
  logic [7:0] q_exp[$];
  op_t        cmd_op;
  int         err_count, n_tests;

  i2c_link_if bus ();
  i2c_link_if bus_b ();

  ////////////////////////////////////////
  // Ends under test and the checker
  i2c_hs_master u_i2c_hs_master (.clk_sys, .arst_n, .bus(bus), .cmd_valid, .cmd_op, .cmd_ready,
    .rsp_valid, .rsp_found, .rsp_addr, .hs_active);
  i2c_alert_slave #(.TMO_CYCLES(TMO)) u_i2c_alert_slave (.clk_sys, .arst_n, .bus(bus), .alert_set,
    .address_select_low_pin(pins[0]), .address_select_high_pin(pins[1]), .alert_n_o, .hs_mode_o);
  i2c_alert_slave #(.TMO_CYCLES(TMO)) u_i2c_alert_slave_b (.clk_sys, .arst_n, .bus(bus_b),
    .alert_set(alert_set_b), .address_select_low_pin(pins_b[0]), .address_select_high_pin(pins_b[1]),
    .alert_n_o(alert_n_b), .hs_mode_o());
  i2c_link_properties #(.TMO_CYCLES(TMO)) u_i2c_link_properties (.clk_sys, .arst_n,
    .s_sda_oe(bus.s_sda_oe), .scl_in(bus.scl_in), .sda_in(bus.sda_in), .hs_mode_o, .alert_n_o, .hs_active);

  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One master command, waits for the end to be ready again
  task automatic run_cmd(input op_t op, input logic [7:0] exp);
    int n;
    if (op != OP_STOP)
      q_exp.push_back(exp);
    @(posedge clk_sys);
    #1 cmd_valid = 1'b1;
    cmd_op = op;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 30000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 30000)
      check(8'h00, 8'hFF);
    #1;
  endtask

  // Bench-driven second link: one quarter of a bit
  task automatic qtr(input logic c, input logic d);
    #QB bus_b.m_scl_oe = c;
    bus_b.m_sda_oe = d;
  endtask

  task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx_o);
    rx_o = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      qtr(1'b1, !tx[i]);
      qtr(1'b0, !tx[i]);
      qtr(1'b0, !tx[i]);
      rx_o[i] = bus_b.sda_in;
      qtr(1'b1, !tx[i]);
    end
  endtask

  task automatic start_b();
    qtr(1'b1, 1'b0);
    qtr(1'b0, 1'b0);
    qtr(1'b0, 1'b1);
    qtr(1'b1, 1'b1);
  endtask

  task automatic stop_b();
    qtr(1'b1, 1'b1);
    qtr(1'b0, 1'b1);
    qtr(1'b0, 1'b0);
  endtask

  // Responses against queued notes
  always @(posedge clk_sys)
  begin
    if (rsp_valid === 1'b1)
    begin
      e = (q_exp.size() > 0) ? q_exp.pop_front() : 8'hXX;
      check({rsp_found, e[7] ? rsp_addr : 7'h00}, e);
      check(8'(alert_n_o), 8'h01);
    end
  end

  // Watchdog
  initial
  begin
    #450000;
    err_count++;
    finish_test();
  end

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {cmd_valid, alert_set, alert_set_b, pins, pins_b, arst_n} = '0;
    cmd_op = OP_HS;
    {bus_b.m_scl_o, bus_b.m_sda_o, bus_b.m_scl_oe, bus_b.m_sda_oe} = 4'h0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'h0AA11D70));
    repeat (12) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    // Alert responses at normal rate, then at high speed
    for (int k = 0; k < 8; k++)
    begin
      if (k == 4)
      begin
        run_cmd(OP_HS, 8'h00);
        check(8'({hs_mode_o, hs_active}), 8'h03);
      end
      al = (k % 4 != 2);
      @(posedge clk_sys);
      #1 pins = 2'(k + k / 4);
      alert_set = al;
      @(posedge clk_sys);
      #1 alert_set = 1'b0;
      run_cmd(OP_ARA, al ? {1'b1, SLAVE_ADDR_TOP, pins} : 8'h00);
    end
    run_cmd(OP_STOP, 8'h00);
    repeat (8) @(posedge clk_sys);
    check(8'({hs_mode_o, hs_active}), 8'h00);
    // Second link: arbitration lost against a lower address
    #1 pins_b = 2'($urandom_range(1, 3));
    alert_set_b = 1'b1;
    @(posedge clk_sys);
    #1 alert_set_b = 1'b0;
    #0.25;  // Link clock edges off the system clock grid
    start_b();
    xfer(9, 9'h033, rx);
    check(8'(rx[0]), 8'h00);
    xfer(9, 9'h101, rx);
    check(rx[8:1], 8'h80);
    check(8'(alert_n_b), 8'h00);
    stop_b();
    // Second link: stall with the slave pulling SDA
    start_b();
    xfer(9, 9'h033, rx);
    xfer(1, 9'h001, rx);
    repeat (4) @(posedge clk_sys);
    check(8'(bus_b.s_sda_oe), 8'h01);
    repeat (TMO + 40) @(posedge clk_sys);
    #1.25;  // Link clock edges off the system clock grid
    check(8'(bus_b.s_sda_oe), 8'h00);
    stop_b();
    // Second link: winning answer releases the alert
    start_b();
    xfer(9, 9'h033, rx);
    check(8'(rx[0]), 8'h00);
    xfer(9, 9'h1FF, rx);
    check(rx[8:1], {SLAVE_ADDR_TOP, pins_b, 1'b0});
    check(8'(alert_n_b), 8'h01);
    stop_b();
    finish_test();
  end
endmodule
